// ---- logic/dsw_regs.vh ----
// Constants for the dual switch serial control and channel logic.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef DSW_REGS_VH
`define DSW_REGS_VH
`define DSW_FRAME_BITS      5'h10
`define DSW_WATCHDOG_TOGGLE_BIT_BIT        15
`define DSW_ADDR_HI         12
`define DSW_ADDR_LO         9
`define DSW_DUTY_HI         7
`define DSW_DUTY_LO         0
`define DSW_A_PWM0          4'h0
`define DSW_A_PWM1          4'h1
`define DSW_A_CONF0         4'h2
`define DSW_A_CONF1         4'h3
`define DSW_A_OC0           4'h4
`define DSW_A_OC1           4'h5
`define DSW_A_GCR           4'h6
`define DSW_A_RDSEL         4'h7
`define DSW_SEL_PREV        4'hf
`define DSW_CF_ON           0
`define DSW_CF_PWMEN        1
`define DSW_CF_CLKINT       2
`define DSW_CF_DIRDIS       3
`define DSW_CF_PR_HI        7
`define DSW_CF_PR_LO        4
`define DSW_GCR_WDDIS       4
`define DSW_WDTO_MS         310
`define DSW_WAKE_US         50
`define DSW_CLK_MHZ         100
`define DSW_MODE_SLEEP      2'h0
`define DSW_MODE_NORMAL     2'h1
`define DSW_MODE_FAILSAFE   2'h2
`define DSW_MODE_FAULT      2'h3
`endif

// ---- logic/dsw_pwm.v ----
// One channel's PWM phase counter and duty comparison.
// Assumes the clock ticks are single-cycle pulses in the system clock.
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_pwm #(
    parameter DW = 8
) (
    input  wire          clock_i,
    input  wire          rst_i,
    input  wire          tick_i,
    input  wire [DW-1:0] duty_i,
    output reg           wave_o
);
    reg [DW-1:0] phase_ff;

    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            phase_ff <= {DW{1'b0}};
            wave_o   <= 1'b0;
        end
        else
        begin
            if (tick_i)
                phase_ff <= phase_ff + {{(DW-1){1'b0}}, 1'b1};
            wave_o <= (phase_ff < duty_i);
        end
    end
endmodule // dsw_pwm

// ---- logic/dsw_top.v ----
// Serial control port, mode logic and channel target computation.
// Serial pins and inputs are synchronous to clock_i; sclk is oversampled.
// Functional notes
// - Capture input bit on serial clock fall
// - Shift output bit on serial clock rise
// - Deselected: ignore clock, data; output released
// - Frames are sixteen bits, MSB first
// - Address field in bits 12 to 9
// - Output carries selected register or previous frame
// - Without logic supply output shifter unreadable
// - Fail-safe pin low on comm or supply loss
// - Four modes; two independent channels
// - Normal mode: direct, internal or external clock
// - Wake-up resets registers, ready after 50 us
// - Normal flag when awake, no failsafe, no fault
// - Direct mode follows direct input pin
// - Internal-clock bit selects internal clock source
// - External mode takes frequency from PWM clock
// - Target is direct term or gated on-bit
// - Duty value from pulse-width bits 7 to 0
// - PWM up to 1 kHz from either clock
// - Per-channel pulse-width, config, overcurrent registers
// - Latch on select rise, load output on fall
// - Watchdog bit must toggle within 310 ms
// - Reset pin low holds registers at default
`timescale 1ns/1ps
`include "dsw_regs.vh"
module dsw_top #(
    parameter WDTO_CYC = `DSW_WDTO_MS * 100000,
    parameter INT_DIV  = 391
) (
    input  wire       clock_i,
    input  wire       rst_i,
    input  wire       reset_pin_n_i,
    input  wire       chip_select_n_i,
    input  wire       sclk_i,
    input  wire       sdi_i,
    input  wire       logic_supply_ok_i,
    input  wire       ext_pwm_clk_i,
    input  wire [1:0] direct_in_i,
    input  wire       fault_i,
    output reg        sdo_o,
    output reg        sdo_oe_o,
    output reg        failsafe_out_n_o,
    output reg        failsafe_out_n_oe_o,
    output reg        normal_mode_flag_o,
    output reg  [1:0] mode_o,
    output reg        ready_o,
    output reg  [1:0] hson_o
);
    localparam WAKE_CYC = `DSW_WAKE_US * `DSW_CLK_MHZ;
    localparam ST_IDLE  = 1'b0;
    localparam ST_XFER  = 1'b1;

    reg        sclk_d_ff;
    reg        cs_d_ff;
    reg        rst_d_ff;
    reg        ext_d_ff;
    reg        state_ff;
    reg [15:0] sh_in_ff;
    reg [15:0] sh_out_ff;
    reg [15:0] prev_ff;
    reg [4:0]  cnt_ff;
    reg [15:0] pwm_reg_ff [0:1];
    reg [15:0] conf_reg_ff [0:1];
    reg [15:0] oc_reg_ff [0:1];
    reg [15:0] gcr_ff;
    reg [3:0]  rdsel_ff;
    reg        watchdog_toggle_bit_last_ff;
    reg [31:0] wd_cnt_ff;
    reg        wd_lost_ff;
    reg [12:0] wake_cnt_ff;
    reg        awake_ff;
    reg [3:0]  pre_cnt_ff [0:1];
    reg [15:0] int_cnt_ff;
    reg        int_tick_ff;

    wire       sclk_fall = sclk_d_ff & ~sclk_i;
    wire       sclk_rise = ~sclk_d_ff & sclk_i;
    wire       cs_fall   = cs_d_ff & ~chip_select_n_i;
    wire       cs_rise   = ~cs_d_ff & chip_select_n_i;
    wire       wake      = reset_pin_n_i | (|direct_in_i);
    // Direct inputs only wake from sleep; a toggle while awake keeps config
    wire       wake_ev   = (reset_pin_n_i & ~rst_d_ff) | (wake & ~awake_ff);
    wire       watchdog_disable    = gcr_ff[`DSW_GCR_WDDIS];
    wire       fsafe     = (wd_lost_ff & ~watchdog_disable) | ~logic_supply_ok_i;
    wire       regs_clr  = rst_i | ~reset_pin_n_i | wake_ev | fsafe;
    wire [3:0] frm_addr  = sh_in_ff[`DSW_ADDR_HI:`DSW_ADDR_LO];
    wire       ext_tick  = ext_pwm_clk_i & ~ext_d_ff;
    wire [1:0] wave;
    wire [1:0] tick;

    // Word to preload into the output shifter for a given select code
    function [15:0] rd_word;
        input [3:0] sel;
        begin
            case (sel)
                `DSW_A_PWM0:   rd_word = pwm_reg_ff[0];
                `DSW_A_PWM1:   rd_word = pwm_reg_ff[1];
                `DSW_A_CONF0:  rd_word = conf_reg_ff[0];
                `DSW_A_CONF1:  rd_word = conf_reg_ff[1];
                `DSW_A_OC0:    rd_word = oc_reg_ff[0];
                `DSW_A_OC1:    rd_word = oc_reg_ff[1];
                `DSW_A_GCR:    rd_word = gcr_ff;
                `DSW_SEL_PREV: rd_word = prev_ff;
                default:       rd_word = {3'h0, mode_o, hson_o,
                                          wd_lost_ff, 8'h00};
            endcase
        end
    endfunction
    wire [15:0] rd_cur = rd_word(rdsel_ff);

    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            sclk_d_ff <= 1'b0;
            cs_d_ff   <= 1'b1;
            rst_d_ff  <= 1'b0;
            ext_d_ff  <= 1'b0;
        end
        else
        begin
            sclk_d_ff <= sclk_i;
            cs_d_ff   <= chip_select_n_i;
            rst_d_ff  <= reset_pin_n_i;
            ext_d_ff  <= ext_pwm_clk_i;
        end
    end

    // Serial engine; registers cleared on wake, reset pin low, fail-safe
    always @(posedge clock_i)
    begin
        if (regs_clr)
        begin
            state_ff       <= ST_IDLE;
            sh_in_ff       <= 16'h0000;
            sh_out_ff      <= 16'h0000;
            cnt_ff         <= 5'h00;
            pwm_reg_ff[0]  <= 16'h0000;
            pwm_reg_ff[1]  <= 16'h0000;
            conf_reg_ff[0] <= 16'h0000;
            conf_reg_ff[1] <= 16'h0000;
            oc_reg_ff[0]   <= 16'h0000;
            oc_reg_ff[1]   <= 16'h0000;
            gcr_ff         <= 16'h0000;
            rdsel_ff       <= `DSW_SEL_PREV;
            prev_ff        <= 16'h0000;
            sdo_o          <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (cs_fall)
                    begin
                        state_ff  <= ST_XFER;
                        cnt_ff    <= 5'h00;
                        sh_out_ff <= rd_cur;
                        sdo_o     <= rd_cur[15];
                    end
                end
                ST_XFER:
                begin
                    if (sclk_fall)
                    begin
                        sh_in_ff <= {sh_in_ff[14:0], sdi_i};
                        cnt_ff   <= cnt_ff + 5'h01;
                    end
                    if (sclk_rise && cnt_ff != 5'h00)
                    begin
                        sh_out_ff <= {sh_out_ff[14:0], 1'b0};
                        sdo_o     <= sh_out_ff[14];
                    end
                    if (cs_rise)
                    begin
                        state_ff <= ST_IDLE;
                        if (cnt_ff == `DSW_FRAME_BITS)
                        begin
                            prev_ff <= sh_in_ff;
                            case (frm_addr)
                                `DSW_A_PWM0:  pwm_reg_ff[0]  <= sh_in_ff;
                                `DSW_A_PWM1:  pwm_reg_ff[1]  <= sh_in_ff;
                                `DSW_A_CONF0: conf_reg_ff[0] <= sh_in_ff;
                                `DSW_A_CONF1: conf_reg_ff[1] <= sh_in_ff;
                                `DSW_A_OC0:   oc_reg_ff[0]   <= sh_in_ff;
                                `DSW_A_OC1:   oc_reg_ff[1]   <= sh_in_ff;
                                `DSW_A_GCR:   gcr_ff         <= sh_in_ff;
                                `DSW_A_RDSEL: rdsel_ff <= sh_in_ff[3:0];
                                default:      rdsel_ff <= rdsel_ff;
                            endcase
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Output driver enabled only while selected and logic supply present
    always @(posedge clock_i)
    begin
        if (rst_i)
            sdo_oe_o <= 1'b0;
        else
            sdo_oe_o <= ~chip_select_n_i & logic_supply_ok_i;
    end

    // Watchdog: first frame bit must alternate; held in reset while off
    always @(posedge clock_i)
    begin
        if (rst_i || !reset_pin_n_i || wake_ev || watchdog_disable)
        begin
            watchdog_toggle_bit_last_ff <= 1'b0;
            wd_cnt_ff    <= 32'h0;
            wd_lost_ff   <= 1'b0;
        end
        else
        begin
            if (state_ff == ST_XFER && cs_rise
                && cnt_ff == `DSW_FRAME_BITS
                && sh_in_ff[`DSW_WATCHDOG_TOGGLE_BIT_BIT] != watchdog_toggle_bit_last_ff)
            begin
                watchdog_toggle_bit_last_ff <= sh_in_ff[`DSW_WATCHDOG_TOGGLE_BIT_BIT];
                wd_cnt_ff    <= 32'h0;
                // Leaving fail-safe needs a frame whose first bit is one
                if (sh_in_ff[`DSW_WATCHDOG_TOGGLE_BIT_BIT])
                    wd_lost_ff <= 1'b0;
            end
            else if (wd_cnt_ff >= WDTO_CYC - 1)
                wd_lost_ff <= 1'b1;
            else
                wd_cnt_ff <= wd_cnt_ff + 32'h1;
        end
    end

    // Mode selection and start-up delay
    always @(posedge clock_i)
    begin
        if (rst_i)
        begin
            awake_ff            <= 1'b0;
            wake_cnt_ff         <= 13'h0000;
            ready_o             <= 1'b0;
            mode_o              <= `DSW_MODE_SLEEP;
            normal_mode_flag_o  <= 1'b0;
            failsafe_out_n_o    <= 1'b0;
            failsafe_out_n_oe_o <= 1'b0;
        end
        else
        begin
            awake_ff <= wake;
            if (wake_ev || !wake)
            begin
                wake_cnt_ff <= 13'h0000;
                ready_o     <= 1'b0;
            end
            else if (wake_cnt_ff == WAKE_CYC[12:0] - 13'h0001)
                ready_o <= 1'b1;
            else
                wake_cnt_ff <= wake_cnt_ff + 13'h0001;
            if (!wake)
                mode_o <= `DSW_MODE_SLEEP;
            else if (fault_i)
                mode_o <= `DSW_MODE_FAULT;
            else if (fsafe)
                mode_o <= `DSW_MODE_FAILSAFE;
            else
                mode_o <= `DSW_MODE_NORMAL;
            normal_mode_flag_o  <= wake & ~fsafe & ~fault_i;
            failsafe_out_n_o    <= 1'b0;
            failsafe_out_n_oe_o <= wake & fsafe;
        end
    end

    // Internal oscillator tick, divided per channel by its prescaler
    always @(posedge clock_i)
    begin
        if (rst_i || int_cnt_ff == INT_DIV - 1)
        begin
            int_cnt_ff  <= 16'h0000;
            int_tick_ff <= ~rst_i;
        end
        else
        begin
            int_cnt_ff  <= int_cnt_ff + 16'h0001;
            int_tick_ff <= 1'b0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_ch
            wire [15:0] cf    = conf_reg_ff[g];
            wire        ptick = (pre_cnt_ff[g] == cf[`DSW_CF_PR_HI:
                                                     `DSW_CF_PR_LO]);
            // Clock source select per channel
            assign tick[g] = cf[`DSW_CF_CLKINT] ? (int_tick_ff & ptick)
                                                : ext_tick;
            always @(posedge clock_i)
            begin
                if (rst_i || (int_tick_ff && ptick))
                    pre_cnt_ff[g] <= 4'h0;
                else if (int_tick_ff)
                    pre_cnt_ff[g] <= pre_cnt_ff[g] + 4'h1;
            end
            dsw_pwm #(
                .DW (8)
            ) u_pwm (
                .clock_i (clock_i),
                .rst_i   (rst_i),
                .tick_i  (tick[g]),
                .duty_i  (pwm_reg_ff[g][`DSW_DUTY_HI:`DSW_DUTY_LO]),
                .wave_o  (wave[g])
            );
            always @(posedge clock_i)
            begin
                if (rst_i)
                    hson_o[g] <= 1'b0;
                else if (!wake || fault_i)
                    hson_o[g] <= 1'b0;
                else if (fsafe || !reset_pin_n_i)
                    hson_o[g] <= direct_in_i[g];
                else
                    hson_o[g] <= (direct_in_i[g] & ~cf[`DSW_CF_DIRDIS])
                        | (cf[`DSW_CF_ON] & wave[g] & cf[`DSW_CF_PWMEN])
                        | (cf[`DSW_CF_ON] & ~cf[`DSW_CF_PWMEN]);
            end
        end
    endgenerate
endmodule // dsw_top

// ---- bench/dsw_monitor.sv ----
// Port checker for dsw_top, bound to every instance of it.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module dsw_monitor #(
    parameter WDTO_CYC = 2000,
    parameter INT_DIV  = 391
) (
    input wire       clock_i,
    input wire       rst_i,
    input wire       reset_pin_n_i,
    input wire       chip_select_n_i,
    input wire       sclk_i,
    input wire       logic_supply_ok_i,
    input wire [1:0] direct_in_i,
    input wire       fault_i,
    input wire       sdo_o,
    input wire       sdo_oe_o,
    input wire       failsafe_out_n_o,
    input wire       failsafe_out_n_oe_o,
    input wire       normal_mode_flag_o,
    input wire [1:0] mode_o,
    input wire       ready_o,
    input wire [1:0] hson_o
);
    // Cycles since the reset pin rose, saturating past the ready window
    reg [12:0] wake_age_ff;
    always @(posedge clock_i)
    begin
        if (rst_i || !reset_pin_n_i)
            wake_age_ff <= 13'h0000;
        else if (wake_age_ff != 13'h13a9)
            wake_age_ff <= wake_age_ff + 13'h0001;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_desel_release: assert property (chip_select_n_i[*4] |-> !sdo_oe_o)
        else $error("sdo driven while deselected");
    a_supply_mute: assert property (!logic_supply_ok_i[*4] |-> !sdo_oe_o)
        else $error("sdo driven without logic supply");
    a_fs_pin_low: assert property (failsafe_out_n_o == 1'b0)
        else $error("fail-safe pin value not low");
    a_supply_failsafe: assert property (
        (!logic_supply_ok_i && reset_pin_n_i && !fault_i)[*8]
        |-> failsafe_out_n_oe_o) else $error("no fail-safe on supply loss");
    a_fs_mode: assert property (
        $rose(failsafe_out_n_oe_o) |-> ##[0:2] mode_o[1])
        else $error("fail-safe pin without fail-safe mode");
    a_fault_mode: assert property (
        (fault_i && reset_pin_n_i)[*4] |-> mode_o == 2'h3)
        else $error("fault not reflected in mode");
    a_flag_mode: assert property (
        normal_mode_flag_o == (mode_o == 2'h1))
        else $error("normal flag disagrees with mode");
    a_wake_early: assert property (
        wake_age_ff >= 13'h0002 && wake_age_ff <= 13'h136b |-> !ready_o)
        else $error("ready high too soon after wake");
    a_wake_ready: assert property (
        wake_age_ff == 13'h13a8 |-> ready_o)
        else $error("ready not 50 us after wake");
    a_dir_follow: assert property (
        (!reset_pin_n_i && !fault_i && $stable(direct_in_i))[*4]
        |-> hson_o == direct_in_i) else $error("hson not following inputs");
    a_sdo_quiet: assert property (
        (!chip_select_n_i && $stable(sclk_i))[*5] |=> $stable(sdo_o))
        else $error("sdo moved without a serial clock rise");
    c_ready: cover property ($rose(ready_o));
    c_frame: cover property ($rose(chip_select_n_i));
    c_failsafe: cover property ($rose(failsafe_out_n_oe_o));
    c_fault: cover property (mode_o == 2'h3);
endmodule // dsw_monitor

bind dsw_top dsw_monitor #(.WDTO_CYC(WDTO_CYC), .INT_DIV(INT_DIV)) dsw_mon_i (
    .clock_i(clock_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
    .chip_select_n_i(chip_select_n_i), .sclk_i(sclk_i),
    .logic_supply_ok_i(logic_supply_ok_i), .direct_in_i(direct_in_i),
    .fault_i(fault_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .failsafe_out_n_o(failsafe_out_n_o),
    .failsafe_out_n_oe_o(failsafe_out_n_oe_o),
    .normal_mode_flag_o(normal_mode_flag_o), .mode_o(mode_o),
    .ready_o(ready_o), .hson_o(hson_o));

// ---- bench/dsw_host.sv ----
// Host serial master model driving select, serial clock and data in.
// Assumes the bench clock; each serial level lasts four system clocks.
`timescale 1ns/1ps
module dsw_host (
    input  wire clock_i,
    input  wire sdo_i,
    output reg  chip_select_n_o,
    output reg  sclk_o,
    output reg  sdi_o
);
    initial
    begin
        chip_select_n_o = 1'b1;
        sclk_o          = 1'b0;
        sdi_o           = 1'b0;
    end
    task automatic idle(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    // Sends the top n bits of w; with sel low select stays high as noise
    task automatic xfer(input [15:0] w, input integer n, input sel,
                        output [15:0] r);
        integer i;
        begin
            r = 16'h0000;
            chip_select_n_o <= !sel;
            idle(6);
            for (i = 15; i > 15 - n; i = i - 1)
            begin
                sclk_o <= 1'b1;
                sdi_o  <= w[i];
                idle(4);
                r[i] = sdo_i;
                sclk_o <= 1'b0;
                idle(4);
            end
            // Data line falls back to its pull-down once released
            sdi_o <= 1'b0;
            chip_select_n_o <= 1'b1;
            idle(6);
        end
    endtask
endmodule // dsw_host

// ---- bench/tb.sv ----
// Self-checking bench for dsw_top with a host model and reference model.
// Assumes 100 MHz; watchdog count shortened to keep the run brief.
`timescale 1ns/1ps
module tb;
    localparam WDTO = 8000;
    reg         clock_i, rst_i, pin_n, supply_ok, fault, wd, prev_ok;
    reg  [1:0]  din;
    reg  [6:0]  pc;
    reg  [15:0] lf, prev, rd;
    reg  [7:0]  cfg [0:1];
    integer     err_count, comparisons, k;
    wire        cs_n, sclk, sdi, sdo, sdo_oe, fs_n, fs_oe, nflag, rdy;
    wire [1:0]  mode, hson;
    dsw_host host_i (.clock_i(clock_i), .sdo_i(sdo),
        .chip_select_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
    dsw_top #(.WDTO_CYC(WDTO), .INT_DIV(8)) dsw_top_i (
        .clock_i(clock_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
        .chip_select_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
        .logic_supply_ok_i(supply_ok), .ext_pwm_clk_i(pc[6]),
        .direct_in_i(din), .fault_i(fault), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .failsafe_out_n_o(fs_n), .failsafe_out_n_oe_o(fs_oe),
        .normal_mode_flag_o(nflag), .mode_o(mode), .ready_o(rdy),
        .hson_o(hson));
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) pc <= pc + 7'h01;
    task automatic tick(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    task close_out;
        begin
            $display("errors %0d comparisons %0d", err_count, comparisons);
            if (err_count == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk_pin(input string n, input [1:0] e, input [1:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e)
            begin
                err_count = err_count + 1;
                $display("BAD %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task chk_word(input string n, input [15:0] e, input [15:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e)
            begin
                err_count = err_count + 1;
                $display("BAD %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Config: bit3 direct disable, bit1 pwm enable, bit0 on
    function [7:0] cv(input [2:0] v);
        cv = {4'h0, v[0], 1'b0, v[1], v[2]};
    endfunction
    // Pulse widths stay zero, so an enabled PWM term is always off
    function [1:0] exp_hs(input [1:0] d);
        integer c;
        begin
            for (c = 0; c < 2; c = c + 1)
                exp_hs[c] = (d[c] & !cfg[c][3]) | (cfg[c][0] & !cfg[c][1]);
        end
    endfunction
    task send(input [3:0] a, input [7:0] d);
        reg [15:0] w;
        begin
            wd = !wd;
            w = {wd, 2'b00, a, 1'b0, d};
            host_i.xfer(w, 16, 1'b1, rd);
            if (prev_ok)
                chk_word("echo", prev, rd);
            prev = w;
            prev_ok = 1'b1;
            if (a == 4'h2 || a == 4'h3)
                cfg[a[0]] = d;
        end
    endtask
    task stim;
        begin
            lf = lfsr(lf);
            // Leaving sleep through a direct input wakes and clears the echo
            if (!pin_n && din == 2'b00 && lf[1:0] != 2'b00)
                prev_ok = 1'b0;
            din <= lf[1:0];
            tick(6);
            chk_pin("hson", exp_hs(din), hson);
        end
    endtask
    task wake;
        begin
            pin_n <= 1'b1;
            cfg[0] = 8'h00;
            cfg[1] = 8'h00;
            prev = 16'h0000;
            prev_ok = 1'b1;
            wd = 1'b0;
            tick(4950);
            chk_pin("ready", 2'b00, {1'b0, rdy});
            k = 0;
            while (rdy !== 1'b1 && k < 200)
            begin
                tick(1);
                k = k + 1;
            end
            chk_pin("ready", 2'b01, {1'b0, rdy});
            if (rdy !== 1'b1)
                close_out;
            chk_pin("mode", 2'h1, mode);
            chk_pin("nflag", 2'b01, {1'b0, nflag});
        end
    endtask
    initial
    begin
        tick(100000);
        err_count = err_count + 1;
        close_out;
    end
    initial
    begin
        rst_i = 1'b1;
        pin_n = 1'b0;
        supply_ok = 1'b1;
        fault = 1'b0;
        din = 2'b00;
        pc = 7'h00;
        lf = 16'h4135;
        err_count = 0;
        comparisons = 0;
        tick(5);
        rst_i <= 1'b0;
        tick(2);
        wake;
        send(4'h7, 8'h0f);
        send(4'h0, 8'h00);
        send(4'h1, 8'h00);
        send(4'h6, 8'h00);
        for (k = 0; k < 8; k = k + 1)
        begin
            stim;
            send(4'h2, cv(k[2:0]));
            send(4'h3, cv(k[2:0] ^ 3'h5));
            tick(4);
            chk_pin("hson", exp_hs(din), hson);
        end
        host_i.xfer(16'h0401, 16, 1'b0, rd);
        stim;
        host_i.xfer(16'h0401, 15, 1'b1, rd);
        stim;
        send(4'h2, 8'h01);
        send(4'h3, 8'h08);
        stim;
        // Half duty on the internal clock, direct input masked: one full
        // period of 256 ticks of 8 clocks must be high for exactly half
        send(4'h0, 8'h80);
        send(4'h2, 8'h0f);
        k = 0;
        repeat (2048)
        begin
            tick(1);
            k = k + hson[0];
        end
        chk_word("duty", 16'h0400, k[15:0]);
        fault <= 1'b1;
        tick(6);
        chk_pin("mode", 2'h3, mode);
        chk_pin("nflag", 2'b00, {1'b0, nflag});
        fault <= 1'b0;
        tick(6);
        chk_pin("mode", 2'h1, mode);
        supply_ok <= 1'b0;
        tick(10);
        chk_pin("fsafe", 2'b01, {1'b0, fs_oe});
        chk_pin("mode", 2'h2, mode);
        host_i.xfer(16'h8401, 16, 1'b1, rd);
        rst_i <= 1'b1;
        pin_n <= 1'b0;
        supply_ok <= 1'b1;
        tick(5);
        rst_i <= 1'b0;
        tick(2);
        wake;
        send(4'h6, 8'h10);
        tick(WDTO + 500);
        chk_pin("fsafe", 2'b00, {1'b0, fs_oe});
        send(4'h6, 8'h00);
        tick(WDTO - 1000);
        chk_pin("fsafe", 2'b00, {1'b0, fs_oe});
        tick(1500);
        chk_pin("fsafe", 2'b01, {1'b0, fs_oe});
        chk_pin("mode", 2'h2, mode);
        pin_n <= 1'b0;
        cfg[0] = 8'h00;
        cfg[1] = 8'h00;
        for (k = 0; k < 8; k = k + 1)
            stim;
        close_out;
    end
endmodule // tb
